// *** msc_cfg.sv ***
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// apb register bank for start-up and closed-loop motor settings
module msc_cfg (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] startup_mode,
    input wire logic open_loop_first,
    output logic [4:0] align_code,
    output logic [8:0] align_angle_deg,
    output logic [9:0] first_cycle_pct_x10,
    output logic first_cycle_zero_hz,
    output logic [7:0] merge_ramp_x100,
    output logic overmod_en,
    output logic [31:0] closed_loop_settings
);
    typedef struct packed {
        logic [31:0] startup;
        logic [31:0] closed_loop;
        logic [4:0] angle_held;
        logic bad_angle;
        logic [31:0] rdata;
        logic slverr;
    } msc_state_s;

    msc_state_s st_r;
    msc_state_s st_nxt;
    logic [8:0] lut_angle;
    logic [9:0] lut_pct;
    logic [7:0] lut_ramp;
    logic src_applies;

    // byte-lane merge under pstrb
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        end
        merge_bytes = r;
    endfunction

    // address is mapped
    function automatic logic hit(input logic [11:0] a);
        hit = (a == msc_pkg::ADDR_STARTUP) || (a == msc_pkg::ADDR_CLOSED_LOOP) || (a == msc_pkg::ADDR_STATUS);
    endfunction

    wire logic wr_en = psel && penable && pwrite;
    wire logic rd_en = psel && penable && !pwrite;

    // register next-state
    always_comb
    begin
        st_nxt = st_r;
        if (wr_en && paddr == msc_pkg::ADDR_STARTUP)
            st_nxt.startup = merge_bytes(st_r.startup, pwdata, pstrb);
        if (wr_en && paddr == msc_pkg::ADDR_CLOSED_LOOP)
            st_nxt.closed_loop = merge_bytes(st_r.closed_loop, pwdata, pstrb);
        // only defined codes reach the angle path; read back from the copy, no net loop through a wire
        if (st_nxt.startup[msc_pkg::ANGLE_LSB +: 5] <= msc_pkg::ANGLE_MAX_CODE)
        begin
            st_nxt.angle_held = st_nxt.startup[msc_pkg::ANGLE_LSB +: 5];
            st_nxt.bad_angle = 1'b0;
        end
        else
            st_nxt.bad_angle = 1'b1;
        st_nxt.slverr = (psel && penable) ? !hit(paddr) : 1'b0;
        st_nxt.rdata = st_r.rdata;
        if (rd_en)
        begin
            unique case (paddr)
                msc_pkg::ADDR_STARTUP: st_nxt.rdata = st_r.startup;
                msc_pkg::ADDR_CLOSED_LOOP: st_nxt.rdata = st_r.closed_loop;
                msc_pkg::ADDR_STATUS: st_nxt.rdata = {26'h0, st_r.bad_angle, st_r.angle_held};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r.startup <= msc_pkg::STARTUP_RST;
            st_r.closed_loop <= msc_pkg::CLOSED_LOOP_RST;
            st_r.angle_held <= 5'h00;
            st_r.bad_angle <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
            st_r.slverr <= 1'b0;
        end
        else
            st_r <= st_nxt;
    end

    // value tables, one cycle behind the fields
    msc_lut u_lut (
        .pclk(pclk),
        .presetn(presetn),
        .angle_code(st_r.angle_held),
        .pct_code(st_r.startup[msc_pkg::PCT_LSB +: 4]),
        .ramp_code(st_r.startup[msc_pkg::RAMP_LSB +: 3]),
        .angle_deg(lut_angle),
        .pct_x10(lut_pct),
        .ramp_mdeg_per_ms_x10(lut_ramp)
    );

    // zero-hz only for align-type options in open-loop first cycle
    assign src_applies = open_loop_first && (startup_mode != msc_pkg::MSC_SU_SLOW_FIRST);
    assign first_cycle_zero_hz = src_applies && st_r.startup[msc_pkg::SRC_BIT];
    assign first_cycle_pct_x10 = first_cycle_zero_hz ? 10'h000 : lut_pct;
    assign align_code = st_r.angle_held;
    assign align_angle_deg = lut_angle;
    assign merge_ramp_x100 = lut_ramp;
    assign overmod_en = st_r.closed_loop[msc_pkg::OVERMOD_BIT];
    assign closed_loop_settings = st_r.closed_loop;

    // one-wait-state slave: read data registered at the access edge is late, so hold one extra cycle
    logic acc_seen_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_seen_r <= 1'b0;
        else
            acc_seen_r <= psel && penable && !acc_seen_r;
    end
    assign pready = acc_seen_r;
    assign prdata = st_r.rdata;
    assign pslverr = acc_seen_r && st_r.slverr;

    // writes land at both access edges, since wr_en is not gated by pready; second edge rewrites same value harmlessly

    // overmodulation follows its settings bit with no extra delay
    property p_ovm;
        @(posedge pclk) disable iff (!presetn)
        overmod_en == closed_loop_settings[30];
    endproperty
    a_ovm: assert property (p_ovm) else $error("overmod enable not bit 30");
    property p_cl_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == 12'h088 && pstrb == 4'hF) |=> closed_loop_settings == $past(pwdata);
    endproperty
    a_cl_write: assert property (p_cl_write) else $error("closed-loop write lost");
    property p_zero_hz;
        @(posedge pclk) disable iff (!presetn) first_cycle_zero_hz |-> first_cycle_pct_x10 == 10'h000;
    endproperty
    a_zero_hz: assert property (p_zero_hz) else $error("zero hz but percent nonzero");
    property p_src_scope;
        @(posedge pclk) disable iff (!presetn) (startup_mode == 2'd3 || !open_loop_first) |-> !first_cycle_zero_hz;
    endproperty
    a_src_scope: assert property (p_src_scope) else $error("select used outside align options");
    property p_angle_valid;
        @(posedge pclk) disable iff (!presetn) align_code <= 5'h1C;
    endproperty
    a_angle_valid: assert property (p_angle_valid) else $error("undefined align code passed");
    property p_angle_hold;
        @(posedge pclk) disable iff (!presetn) st_r.startup[12:8] > 5'h1C |-> $stable(align_code);
    endproperty
    a_angle_hold: assert property (p_angle_hold) else $error("angle moved on bad code");
    property p_angle_max;
        @(posedge pclk) disable iff (!presetn) align_code == 5'h1C ##1 align_code == 5'h1C |-> ##0 align_angle_deg == 9'd350;
    endproperty
    a_angle_max: assert property (p_angle_max) else $error("code 1C not 350 deg");
    property p_pct_max;
        @(posedge pclk) disable iff (!presetn)
        (st_r.startup[7:4] == 4'hF && !first_cycle_zero_hz) ##1 (st_r.startup[7:4] == 4'hF && !first_cycle_zero_hz)
        |-> first_cycle_pct_x10 == 10'd500;
    endproperty
    a_pct_max: assert property (p_pct_max) else $error("code F not 50 pct");
    property p_ramp_max;
        @(posedge pclk) disable iff (!presetn) st_r.startup[2:0] == 3'h7 |=> merge_ramp_x100 == 8'd200;
    endproperty
    a_ramp_max: assert property (p_ramp_max) else $error("ramp code 7 not 2 deg per ms");
    property p_ready;
        @(posedge pclk) disable iff (!presetn) (psel && penable && !pready) |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready late");

    // bus answer shape: one ready cycle, error only with ready
    property p_ready_one;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");

    property p_ready_cause;
        @(posedge pclk) disable iff (!presetn)
        pready |-> $past(psel && penable);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("pready without access");

    property p_err_with_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

    property p_err_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (pready && psel && penable && !hit(paddr)) |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

    property p_err_mapped;
        @(posedge pclk) disable iff (!presetn)
        (pready && psel && penable && hit(paddr)) |-> !pslverr;
    endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

    // read data of each register
    property p_rd_zero;
        @(posedge pclk) disable iff (!presetn)
        (pready && psel && !pwrite && !hit(paddr)) |-> prdata == 32'h0000_0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");

    property p_rd_cl;
        @(posedge pclk) disable iff (!presetn)
        (pready && psel && !pwrite && paddr == 12'h088) |-> prdata == closed_loop_settings;
    endproperty
    a_rd_cl: assert property (p_rd_cl) else $error("closed-loop read differs");

    property p_rd_startup;
        @(posedge pclk) disable iff (!presetn)
        (pready && psel && !pwrite && paddr == msc_pkg::ADDR_STARTUP) |-> prdata == st_r.startup;
    endproperty
    a_rd_startup: assert property (p_rd_startup) else $error("start-up read differs");

    property p_rd_status;
        @(posedge pclk) disable iff (!presetn)
        (pready && psel && !pwrite && paddr == msc_pkg::ADDR_STATUS) |-> prdata[31:6] == 26'h0;
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status upper bits set");

    // refused or masked writes leave the settings alone
    property p_no_write_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && !hit(paddr)) |=> $stable(closed_loop_settings);
    endproperty
    a_no_write_unmapped: assert property (p_no_write_unmapped) else $error("unmapped write landed");

    property p_no_lanes;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == 12'h088 && pstrb == 4'h0) |=> $stable(closed_loop_settings);
    endproperty
    a_no_lanes: assert property (p_no_lanes) else $error("write with no lanes landed");

    // decode ends and ranges
    property p_src_low;
        @(posedge pclk) disable iff (!presetn)
        !st_r.startup[3] |-> !first_cycle_zero_hz;
    endproperty
    a_src_low: assert property (p_src_low) else $error("zero hz with select low");

    property p_pct_min;
        @(posedge pclk) disable iff (!presetn)
        (st_r.startup[7:4] == 4'h0) ##1 (st_r.startup[7:4] == 4'h0 && !first_cycle_zero_hz)
        |-> first_cycle_pct_x10 == 10'd10;
    endproperty
    a_pct_min: assert property (p_pct_min) else $error("code 0 not 1 pct");

    property p_pct_range;
        @(posedge pclk) disable iff (!presetn)
        first_cycle_pct_x10 <= 10'd500;
    endproperty
    a_pct_range: assert property (p_pct_range) else $error("percent above 50");

    property p_ramp_min;
        @(posedge pclk) disable iff (!presetn)
        st_r.startup[2:0] == 3'h0 |=> merge_ramp_x100 == 8'd1;
    endproperty
    a_ramp_min: assert property (p_ramp_min) else $error("ramp code 0 not 0.01 deg per ms");

    property p_ramp_range;
        @(posedge pclk) disable iff (!presetn)
        merge_ramp_x100 <= 8'd200;
    endproperty
    a_ramp_range: assert property (p_ramp_range) else $error("ramp above 2 deg per ms");

    property p_angle_zero;
        @(posedge pclk) disable iff (!presetn)
        align_code == 5'h00 ##1 align_code == 5'h00 |-> ##0 align_angle_deg == 9'd0;
    endproperty
    a_angle_zero: assert property (p_angle_zero) else $error("code 0 not 0 deg");

    property p_angle_range;
        @(posedge pclk) disable iff (!presetn)
        align_angle_deg <= 9'd350;
    endproperty
    a_angle_range: assert property (p_angle_range) else $error("angle above 350 deg");

    // a defined code passes straight through to the held code
    property p_align_follows;
        @(posedge pclk) disable iff (!presetn)
        st_r.startup[12:8] <= 5'h1C |-> align_code == st_r.startup[12:8];
    endproperty
    a_align_follows: assert property (p_align_follows) else $error("defined code not taken");
    c_cl_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en && paddr == 12'h088 && pready);
    c_zero_hz: cover property (@(posedge pclk) disable iff (!presetn) first_cycle_zero_hz);
    c_bad_angle: cover property (@(posedge pclk) disable iff (!presetn) st_r.bad_angle);
    c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// *** msc_pkg.sv ***
// shared constants and types for the motor start-up / closed-loop config bank
package msc_pkg;
    // register byte offsets
    localparam logic [11:0] ADDR_STARTUP = 12'h084;
    localparam logic [11:0] ADDR_CLOSED_LOOP = 12'h088;
    localparam logic [11:0] ADDR_STATUS = 12'h08C;
    // reset values
    localparam logic [31:0] STARTUP_RST = 32'h0000_0000;
    localparam logic [31:0] CLOSED_LOOP_RST = 32'h0000_0000;
    // field positions
    localparam int ANGLE_LSB = 8;
    localparam int PCT_LSB = 4;
    localparam int SRC_BIT = 3;
    localparam int RAMP_LSB = 0;
    localparam int OVERMOD_BIT = 30;
    // largest defined align code
    localparam logic [4:0] ANGLE_MAX_CODE = 5'h1C;
    // start-up options
    typedef enum logic [1:0] {MSC_SU_ALIGN, MSC_SU_DBL_ALIGN, MSC_SU_IPD, MSC_SU_SLOW_FIRST} msc_startup_e;
    // apb access phases
    typedef enum logic [1:0] {MSC_ST_IDLE, MSC_ST_ACCESS} msc_phase_e;
endpackage

// *** msc_lut.sv ***
`timescale 1ns/1ps
// code to value lookup tables, registered outputs
module msc_lut (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] angle_code,
    input wire logic [3:0] pct_code,
    input wire logic [2:0] ramp_code,
    output logic [8:0] angle_deg,
    output logic [9:0] pct_x10,
    output logic [7:0] ramp_mdeg_per_ms_x10
);
    // angle table in whole degrees
    function automatic logic [8:0] angle_of(input logic [4:0] c);
        logic [8:0] t [0:28];
        t = '{9'd0, 9'd10, 9'd20, 9'd30, 9'd45, 9'd60, 9'd70, 9'd80, 9'd90, 9'd110, 9'd120, 9'd135,
              9'd150, 9'd160, 9'd170, 9'd180, 9'd190, 9'd210, 9'd225, 9'd240, 9'd250, 9'd260, 9'd270,
              9'd280, 9'd290, 9'd315, 9'd330, 9'd340, 9'd350};
        angle_of = (c <= msc_pkg::ANGLE_MAX_CODE) ? t[c] : 9'd0;
    endfunction
    // percent of top speed, in tenths
    function automatic logic [9:0] pct_of(input logic [3:0] c);
        logic [9:0] t [0:15];
        t = '{10'd10, 10'd20, 10'd30, 10'd50, 10'd75, 10'd100, 10'd125, 10'd150, 10'd175, 10'd200,
              10'd250, 10'd300, 10'd350, 10'd400, 10'd450, 10'd500};
        pct_of = t[c];
    endfunction
    // ramp in hundredths of a degree per ms
    function automatic logic [7:0] ramp_of(input logic [2:0] c);
        logic [7:0] t [0:7];
        t = '{8'd1, 8'd5, 8'd10, 8'd15, 8'd20, 8'd50, 8'd100, 8'd200};
        ramp_of = t[c];
    endfunction

    // registered table outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            angle_deg <= 9'h000;
            pct_x10 <= 10'h000;
            ramp_mdeg_per_ms_x10 <= 8'h00;
        end
        else
        begin
            angle_deg <= angle_of(angle_code);
            pct_x10 <= pct_of(pct_code);
            ramp_mdeg_per_ms_x10 <= ramp_of(ramp_code);
        end
    end
endmodule

// *** msc_cfg_tb.sv ***
`timescale 1ns/1ps
// self-checking apb testbench for the start-up and closed-loop config bank
module msc_cfg_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [1:0] startup_mode = 2'h0;
    logic open_loop_first = 1'b0;
    logic [31:0] prdata, closed_loop_settings, q;
    logic pready, pslverr, first_cycle_zero_hz, overmod_en, err;
    logic [4:0] align_code;
    logic [8:0] align_angle_deg;
    logic [9:0] first_cycle_pct_x10;
    logic [7:0] merge_ramp_x100;
    int n_mismatch = 0;
    int comparisons = 0;
    // expected decode tables, degrees, percent x10 and hundredths deg/ms
    int ang[29] = '{0, 10, 20, 30, 45, 60, 70, 80, 90, 110, 120, 135, 150, 160, 170, 180, 190, 210, 225,
        240, 250, 260, 270, 280, 290, 315, 330, 340, 350};
    int pct[16] = '{10, 20, 30, 50, 75, 100, 125, 150, 175, 200, 250, 300, 350, 400, 450, 500};
    int rmp[8] = '{1, 5, 10, 15, 20, 50, 100, 200};

    // 40 ns period
    always #20 pclk = ~pclk;

    msc_cfg uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .startup_mode(startup_mode), .open_loop_first(open_loop_first),
        .align_code(align_code), .align_angle_deg(align_angle_deg),
        .first_cycle_pct_x10(first_cycle_pct_x10), .first_cycle_zero_hz(first_cycle_zero_hz),
        .merge_ramp_x100(merge_ramp_x100), .overmod_en(overmod_en),
        .closed_loop_settings(closed_loop_settings));

    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; pready, prdata and pslverr taken at the rising edge where pready is high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] pready expected 1 seen %b", pready);
            complete_run;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // decoded outputs trail a write by the register and one table stage
    task settle;
        repeat (3) @(negedge pclk);
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, msc_pkg::ADDR_CLOSED_LOOP, 32'h0);
        chk("cl reset", 32'h0000_0000, q);
        apb(1'b0, msc_pkg::ADDR_STARTUP, 32'h0);
        chk("startup reset", 32'h0000_0000, q);
        // every defined align code, percent code and ramp code in one sweep
        for (int i = 0; i < 29; i++)
        begin
            apb(1'b1, msc_pkg::ADDR_STARTUP, {19'h0, 5'(i), 4'(i % 16), 1'b0, 3'(i % 8)});
            settle;
            chk("angle", 32'(ang[i]), {23'h0, align_angle_deg});
            chk("pct", 32'(pct[i % 16]), {22'h0, first_cycle_pct_x10});
            chk("ramp", 32'(rmp[i % 8]), {24'h0, merge_ramp_x100});
            chk("zero hz", 32'h0, {31'h0, first_cycle_zero_hz});
        end
        // undefined code keeps the last valid angle
        apb(1'b1, msc_pkg::ADDR_STARTUP, 32'h0000_1D00);
        settle;
        chk("held code", 32'h0000_001C, {27'h0, align_code});
        chk("held angle", 32'd350, {23'h0, align_angle_deg});
        apb(1'b0, msc_pkg::ADDR_STARTUP, 32'h0);
        chk("stored code", 32'h0000_1D00, q);
        apb(1'b0, msc_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h0000_003C, q);
        // source select only for align-type open-loop first cycles
        apb(1'b1, msc_pkg::ADDR_STARTUP, 32'h0000_00F8);
        for (int m = 0; m < 8; m++)
        begin
            @(posedge pclk);
            startup_mode <= 2'(m % 4);
            open_loop_first <= m[2];
            settle;
            chk("zero hz", {31'h0, m[2] && (m % 4) != 3}, {31'h0, first_cycle_zero_hz});
            chk("pct sel", (m[2] && (m % 4) != 3) ? 32'd0 : 32'd500, {22'h0, first_cycle_pct_x10});
        end
        // closed-loop settings read/write and overmodulation bit
        apb(1'b1, msc_pkg::ADDR_CLOSED_LOOP, 32'hFFFF_FFFF);
        apb(1'b0, msc_pkg::ADDR_CLOSED_LOOP, 32'h0);
        chk("cl rw", 32'hFFFF_FFFF, q);
        chk("overmod on", 32'h1, {31'h0, overmod_en});
        apb(1'b1, msc_pkg::ADDR_CLOSED_LOOP, 32'hBFFF_FFFF);
        settle;
        chk("overmod off", 32'h0, {31'h0, overmod_en});
        chk("cl port", 32'hBFFF_FFFF, closed_loop_settings);
        // unmapped address refused, nothing written
        apb(1'b1, 12'h090, 32'h1234_5678);
        chk("wr err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h090, 32'h0);
        chk("rd err", 32'h1, {31'h0, err});
        chk("rd zero", 32'h0, q);
        apb(1'b0, msc_pkg::ADDR_CLOSED_LOOP, 32'h0);
        chk("cl kept", 32'hBFFF_FFFF, q);
        complete_run;
    end
endmodule
